// file: rtl/vagr_map.vh
`ifndef VAGR_MAP_VH
`define VAGR_MAP_VH
// ==========================================================
// register indices (printed offsets are not all word multiples)
`define VAGR_IDX_INPUT_SETUP 8'h05
`define VAGR_IDX_RED_GAIN 8'h06
`define VAGR_IDX_GREEN_GAIN 8'h07
`define VAGR_IDX_BLUE_GAIN 8'h08
`define VAGR_IDX_RED_OFFSET 8'h09
`define VAGR_IDX_GREEN_OFFSET 8'h0a
`define VAGR_IDX_BLUE_OFFSET 8'h0b
`define VAGR_IDX_OFFSET_DAC 8'h0c
// ==========================================================
// reset values
`define VAGR_RST_INPUT_SETUP 8'h00
`define VAGR_RST_GAIN 8'h55
`define VAGR_RST_OFFSET 8'h80
`define VAGR_RST_OFFSET_DAC 8'h00
// ==========================================================
// input_setup fields
`define VAGR_BIT_CHAN_SEL 0
`define VAGR_BIT_DC_COUPLED 1
`define VAGR_BIT_YUV 2
`define VAGR_BIT_SYNC_COMPOSITE 3
`define VAGR_BIT_COMPOSITE_SYNC_SRC_HS 4
`define VAGR_BIT_COAST_CLAMP 5
// offset_dac_setup fields
`define VAGR_BIT_DAC_RANGE 0
`define VAGR_LSB_RED 2
`define VAGR_LSB_GREEN 4
`define VAGR_LSB_BLUE 6
// ==========================================================
// analog codes: clamp level select and black targets
`define VAGR_CLAMP_300MV 1'b0
`define VAGR_CLAMP_600MV 1'b1
`define VAGR_TARGET_ZERO 8'h00
`define VAGR_TARGET_MID 8'h80
`define VAGR_DIG_BIAS 8'h80
// ==========================================================
// write masks, reserved bits store zero
`define VAGR_MASK_INPUT_SETUP 8'h3f
`define VAGR_MASK_OFFSET_DAC 8'hfd
// derived output codes, vectors ordered {blue, green, red}
`define VAGR_SHIFT_RGB 3'b111
`define VAGR_SHIFT_YUV 3'b010
`define VAGR_DAC_MID 10'h200
`endif

// file: rtl/vagr_regs.v
// Implementation choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "vagr_map.vh"
module vagr_regs (
   input wire ref_clk,
   input wire reset,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output wire [31:0] hrdata,
   output wire hreadyout,
   output wire hresp,
   input wire auto_black_level,
   input wire pll_coast,
   input wire clamp_time,
   output wire second_input_set,
   output wire pos_to_clamp_dac,
   output wire neg_to_pad,
   output wire neg_to_clamp_dac,
   output wire analog_clamp_on,
   output wire [2:0] clamp_level_sel,
   output wire [2:0] half_shift_en,
   output wire [7:0] red_target,
   output wire [7:0] green_target,
   output wire [7:0] blue_target,
   output wire sync_from_sog,
   output wire composite_mode,
   output wire restore_active,
   output wire [7:0] red_gain,
   output wire [7:0] green_gain,
   output wire [7:0] blue_gain,
   output wire [9:0] red_dac,
   output wire [9:0] green_dac,
   output wire [9:0] blue_dac,
   output wire signed [8:0] red_dig_offset,
   output wire signed [8:0] green_dig_offset,
   output wire signed [8:0] blue_dig_offset,
   output wire dac_quarter_span
);
   // ==========================================================
   // helpers
   function [9:0] dac_code;
      input [7:0] hi;
      input [1:0] lo;
      begin
         dac_code = {hi, lo};
      end
   endfunction

   // offset register as a signed shift, 0x80 meaning zero
   function signed [8:0] dig_shift;
      input [7:0] code;
      begin
         dig_shift = $signed({1'b0, code}) - $signed({1'b0, `VAGR_DIG_BIAS});
      end
   endfunction

   // stored form of a written byte, reserved bits forced to zero
   function [7:0] wr_mask;
      input [7:0] sel;
      input [7:0] data;
      begin
         case (sel)
            `VAGR_IDX_INPUT_SETUP: wr_mask = data & `VAGR_MASK_INPUT_SETUP;
            `VAGR_IDX_OFFSET_DAC: wr_mask = data & `VAGR_MASK_OFFSET_DAC;
            default: wr_mask = data;
         endcase
      end
   endfunction

   // ==========================================================
   // bus slave: zero wait states, always OKAY
   reg [7:0] input_setup_q;
   reg [7:0] red_channel_gain_q;
   reg [7:0] green_channel_gain_q;
   reg [7:0] blue_channel_gain_q;
   reg [7:0] red_channel_offset_q;
   reg [7:0] green_channel_offset_q;
   reg [7:0] blue_channel_offset_q;
   reg [7:0] offset_dac_setup_q;
   reg wr_pend_q;
   reg [7:0] wr_idx_q;
   reg [7:0] rd_data_q;
   reg [7:0] rd_data_d;
   wire take;
   wire [7:0] idx;
   wire [7:0] wr_val;

   assign take = hsel & hready & htrans[1];
   assign wr_val = wr_mask(wr_idx_q, hwdata[7:0]);
   assign idx = haddr[9:2];
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = {24'h000000, rd_data_q};

   always @* begin
      case (idx)
         `VAGR_IDX_INPUT_SETUP: rd_data_d = input_setup_q;
         `VAGR_IDX_RED_GAIN: rd_data_d = red_channel_gain_q;
         `VAGR_IDX_GREEN_GAIN: rd_data_d = green_channel_gain_q;
         `VAGR_IDX_BLUE_GAIN: rd_data_d = blue_channel_gain_q;
         `VAGR_IDX_RED_OFFSET: rd_data_d = red_channel_offset_q;
         `VAGR_IDX_GREEN_OFFSET: rd_data_d = green_channel_offset_q;
         `VAGR_IDX_BLUE_OFFSET: rd_data_d = blue_channel_offset_q;
         `VAGR_IDX_OFFSET_DAC: rd_data_d = offset_dac_setup_q;
         default: rd_data_d = 8'h00;
      endcase
      // a write still in its data phase is forwarded, so an overlapped read sees it
      if (wr_pend_q && (wr_idx_q == idx) && (idx >= `VAGR_IDX_INPUT_SETUP)
          && (idx <= `VAGR_IDX_OFFSET_DAC)) begin
         rd_data_d = wr_val;
      end
   end

   always @(posedge ref_clk) begin
      if (reset) begin
         wr_pend_q <= 1'b0;
         wr_idx_q <= 8'h00;
         rd_data_q <= 8'h00;
      end else begin
         wr_pend_q <= take & hwrite;
         if (take) begin
            wr_idx_q <= idx;
         end
         if (take & ~hwrite) begin
            rd_data_q <= rd_data_d;
         end
      end
   end

   // ==========================================================
   // register bank; written in the data phase
   always @(posedge ref_clk) begin
      if (reset) begin
         input_setup_q <= `VAGR_RST_INPUT_SETUP;
         red_channel_gain_q <= `VAGR_RST_GAIN;
         green_channel_gain_q <= `VAGR_RST_GAIN;
         blue_channel_gain_q <= `VAGR_RST_GAIN;
         red_channel_offset_q <= `VAGR_RST_OFFSET;
         green_channel_offset_q <= `VAGR_RST_OFFSET;
         blue_channel_offset_q <= `VAGR_RST_OFFSET;
         offset_dac_setup_q <= `VAGR_RST_OFFSET_DAC;
      end else if (wr_pend_q) begin
         case (wr_idx_q)
            `VAGR_IDX_INPUT_SETUP: input_setup_q <= wr_val;
            `VAGR_IDX_RED_GAIN: red_channel_gain_q <= wr_val;
            `VAGR_IDX_GREEN_GAIN: green_channel_gain_q <= wr_val;
            `VAGR_IDX_BLUE_GAIN: blue_channel_gain_q <= wr_val;
            `VAGR_IDX_RED_OFFSET: red_channel_offset_q <= wr_val;
            `VAGR_IDX_GREEN_OFFSET: green_channel_offset_q <= wr_val;
            `VAGR_IDX_BLUE_OFFSET: blue_channel_offset_q <= wr_val;
            `VAGR_IDX_OFFSET_DAC: offset_dac_setup_q <= wr_val;
            default: begin
            end
         endcase
      end
   end

   // ==========================================================
   // decoded controls; data outputs come from flops
   wire dc_mode;
   wire yuv_mode;
   wire coast_hold;
   wire [7:0] dsel;
   assign dc_mode = input_setup_q[`VAGR_BIT_DC_COUPLED];
   assign yuv_mode = input_setup_q[`VAGR_BIT_YUV];
   assign dsel = offset_dac_setup_q;
   // pause clamping while coasting unless told to continue
   assign coast_hold = pll_coast & ~input_setup_q[`VAGR_BIT_COAST_CLAMP];

   reg second_input_set_d;
   reg pos_to_clamp_dac_d;
   reg neg_to_pad_d;
   reg neg_to_clamp_dac_d;
   reg analog_clamp_on_d;
   reg [2:0] clamp_level_sel_d;
   reg [2:0] half_shift_en_d;
   reg [7:0] red_target_d;
   reg [7:0] green_target_d;
   reg [7:0] blue_target_d;
   reg sync_from_sog_d;
   reg composite_mode_d;
   reg restore_active_d;
   reg [7:0] red_gain_d;
   reg [7:0] green_gain_d;
   reg [7:0] blue_gain_d;
   reg [9:0] red_dac_d;
   reg [9:0] green_dac_d;
   reg [9:0] blue_dac_d;
   reg signed [8:0] red_dig_offset_d;
   reg signed [8:0] green_dig_offset_d;
   reg signed [8:0] blue_dig_offset_d;
   reg dac_quarter_span_d;

   reg second_input_set_q;
   reg pos_to_clamp_dac_q;
   reg neg_to_pad_q;
   reg neg_to_clamp_dac_q;
   reg analog_clamp_on_q;
   reg [2:0] clamp_level_sel_q;
   reg [2:0] half_shift_en_q;
   reg [7:0] red_target_q;
   reg [7:0] green_target_q;
   reg [7:0] blue_target_q;
   reg sync_from_sog_q;
   reg composite_mode_q;
   reg restore_active_q;
   reg [7:0] red_gain_q;
   reg [7:0] green_gain_q;
   reg [7:0] blue_gain_q;
   reg [9:0] red_dac_q;
   reg [9:0] green_dac_q;
   reg [9:0] blue_dac_q;
   reg signed [8:0] red_dig_offset_q;
   reg signed [8:0] green_dig_offset_q;
   reg signed [8:0] blue_dig_offset_q;
   reg dac_quarter_span_q;

   assign second_input_set = second_input_set_q;
   assign pos_to_clamp_dac = pos_to_clamp_dac_q;
   assign neg_to_pad = neg_to_pad_q;
   assign neg_to_clamp_dac = neg_to_clamp_dac_q;
   assign analog_clamp_on = analog_clamp_on_q;
   assign clamp_level_sel = clamp_level_sel_q;
   assign half_shift_en = half_shift_en_q;
   assign red_target = red_target_q;
   assign green_target = green_target_q;
   assign blue_target = blue_target_q;
   assign sync_from_sog = sync_from_sog_q;
   assign composite_mode = composite_mode_q;
   assign restore_active = restore_active_q;
   assign red_gain = red_gain_q;
   assign green_gain = green_gain_q;
   assign blue_gain = blue_gain_q;
   assign red_dac = red_dac_q;
   assign green_dac = green_dac_q;
   assign blue_dac = blue_dac_q;
   assign red_dig_offset = red_dig_offset_q;
   assign green_dig_offset = green_dig_offset_q;
   assign blue_dig_offset = blue_dig_offset_q;
   assign dac_quarter_span = dac_quarter_span_q;

   // ==========================================================
   // input routing and coupling
   always @* begin
      second_input_set_d = input_setup_q[`VAGR_BIT_CHAN_SEL];
      pos_to_clamp_dac_d = ~dc_mode & clamp_time & ~coast_hold;
      neg_to_pad_d = dc_mode;
      neg_to_clamp_dac_d = ~dc_mode;
      analog_clamp_on_d = ~dc_mode & ~coast_hold;
   end

   // ==========================================================
   // colour space, vectors ordered {blue, green, red}
   always @* begin
      clamp_level_sel_d = {3{`VAGR_CLAMP_300MV}};
      half_shift_en_d = `VAGR_SHIFT_RGB;
      red_target_d = `VAGR_TARGET_ZERO;
      green_target_d = `VAGR_TARGET_ZERO;
      blue_target_d = `VAGR_TARGET_ZERO;
      if (yuv_mode) begin
         clamp_level_sel_d = {`VAGR_CLAMP_600MV, `VAGR_CLAMP_300MV, `VAGR_CLAMP_600MV};
         half_shift_en_d = `VAGR_SHIFT_YUV;
         red_target_d = `VAGR_TARGET_MID;
         blue_target_d = `VAGR_TARGET_MID;
      end
   end

   // ==========================================================
   // sync selection and coast behaviour
   always @* begin
      composite_mode_d = input_setup_q[`VAGR_BIT_SYNC_COMPOSITE];
      // separate sync always takes the horizontal input
      sync_from_sog_d = input_setup_q[`VAGR_BIT_SYNC_COMPOSITE]
                        & ~input_setup_q[`VAGR_BIT_COMPOSITE_SYNC_SRC_HS];
      restore_active_d = ~coast_hold;
   end

   // ==========================================================
   // gain and offset
   always @* begin
      // gain codes only; the analog side maps 0.5 + code/170
      red_gain_d = red_channel_gain_q;
      green_gain_d = green_channel_gain_q;
      blue_gain_d = blue_channel_gain_q;
      dac_quarter_span_d = dsel[`VAGR_BIT_DAC_RANGE];
      // auto black level owns the offset, analog dac parked at mid scale
      red_dac_d = `VAGR_DAC_MID;
      green_dac_d = `VAGR_DAC_MID;
      blue_dac_d = `VAGR_DAC_MID;
      red_dig_offset_d = dig_shift(red_channel_offset_q);
      green_dig_offset_d = dig_shift(green_channel_offset_q);
      blue_dig_offset_d = dig_shift(blue_channel_offset_q);
      if (!auto_black_level) begin
         red_dac_d = dac_code(red_channel_offset_q, dsel[`VAGR_LSB_RED +: 2]);
         green_dac_d = dac_code(green_channel_offset_q, dsel[`VAGR_LSB_GREEN +: 2]);
         blue_dac_d = dac_code(blue_channel_offset_q, dsel[`VAGR_LSB_BLUE +: 2]);
         red_dig_offset_d = 9'sd0;
         green_dig_offset_d = 9'sd0;
         blue_dig_offset_d = 9'sd0;
      end
   end

   // ==========================================================
   // output flops, one cycle behind the registers
   always @(posedge ref_clk) begin
      if (reset) begin
         second_input_set_q <= 1'b0;
         pos_to_clamp_dac_q <= 1'b0;
         neg_to_pad_q <= 1'b0;
         neg_to_clamp_dac_q <= 1'b1;
         analog_clamp_on_q <= 1'b0;
         clamp_level_sel_q <= {3{`VAGR_CLAMP_300MV}};
         half_shift_en_q <= `VAGR_SHIFT_RGB;
         red_target_q <= `VAGR_TARGET_ZERO;
         green_target_q <= `VAGR_TARGET_ZERO;
         blue_target_q <= `VAGR_TARGET_ZERO;
         sync_from_sog_q <= 1'b0;
         composite_mode_q <= 1'b0;
         restore_active_q <= 1'b1;
         red_gain_q <= `VAGR_RST_GAIN;
         green_gain_q <= `VAGR_RST_GAIN;
         blue_gain_q <= `VAGR_RST_GAIN;
         red_dac_q <= `VAGR_DAC_MID;
         green_dac_q <= `VAGR_DAC_MID;
         blue_dac_q <= `VAGR_DAC_MID;
         red_dig_offset_q <= 9'sd0;
         green_dig_offset_q <= 9'sd0;
         blue_dig_offset_q <= 9'sd0;
         dac_quarter_span_q <= 1'b0;
      end else begin
         second_input_set_q <= second_input_set_d;
         pos_to_clamp_dac_q <= pos_to_clamp_dac_d;
         neg_to_pad_q <= neg_to_pad_d;
         neg_to_clamp_dac_q <= neg_to_clamp_dac_d;
         analog_clamp_on_q <= analog_clamp_on_d;
         clamp_level_sel_q <= clamp_level_sel_d;
         half_shift_en_q <= half_shift_en_d;
         red_target_q <= red_target_d;
         green_target_q <= green_target_d;
         blue_target_q <= blue_target_d;
         sync_from_sog_q <= sync_from_sog_d;
         composite_mode_q <= composite_mode_d;
         restore_active_q <= restore_active_d;
         red_gain_q <= red_gain_d;
         green_gain_q <= green_gain_d;
         blue_gain_q <= blue_gain_d;
         red_dac_q <= red_dac_d;
         green_dac_q <= green_dac_d;
         blue_dac_q <= blue_dac_d;
         red_dig_offset_q <= red_dig_offset_d;
         green_dig_offset_q <= green_dig_offset_d;
         blue_dig_offset_q <= blue_dig_offset_d;
         dac_quarter_span_q <= dac_quarter_span_d;
      end
   end
endmodule // vagr_regs

// file: test/vagr_regs_properties.sv
`timescale 1ns/1ps
// ==========================================================
// port relations of the register bank
module vagr_regs_chk (
   input wire ref_clk,
   input wire reset,
   input wire hreadyout,
   input wire hresp,
   input wire auto_black_level,
   input wire pll_coast,
   input wire clamp_time,
   input wire pos_to_clamp_dac,
   input wire neg_to_pad,
   input wire neg_to_clamp_dac,
   input wire analog_clamp_on,
   input wire [2:0] clamp_level_sel,
   input wire [2:0] half_shift_en,
   input wire [7:0] green_target,
   input wire sync_from_sog,
   input wire composite_mode,
   input wire restore_active,
   input wire [9:0] red_dac,
   input wire signed [8:0] red_dig_offset
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   // ==========================================================
   // assertions
   chk_bus_always_okay: assert property (hreadyout && !hresp)
      else $error("bus stalled or not okay");
   chk_ac_pos_path: assert property (pos_to_clamp_dac |-> neg_to_clamp_dac && $past(clamp_time))
      else $error("positive input on clamp dac outside ac clamp time");
   chk_neg_one_side: assert property (neg_to_pad != neg_to_clamp_dac)
      else $error("negative input routing wrong");
   chk_dc_no_clamp: assert property (neg_to_pad |-> !analog_clamp_on && !pos_to_clamp_dac)
      else $error("clamp active in dc mode");
   chk_green_fixed: assert property (!clamp_level_sel[1] && half_shift_en[1] && green_target == 8'h00)
      else $error("green clamp settings wrong");
   chk_yuv_pairs: assert property (clamp_level_sel[0] == clamp_level_sel[2] &&
      half_shift_en[0] != clamp_level_sel[0])
      else $error("red and blue colour settings disagree");
   chk_sog_composite: assert property (sync_from_sog |-> composite_mode)
      else $error("sync on green chosen with separate sync");
   chk_coast_pause: assert property (!restore_active |-> $past(pll_coast) && !analog_clamp_on)
      else $error("restore paused without coast");
   chk_dac_mid: assert property ($past(auto_black_level) |-> red_dac == 10'h200)
      else $error("analog dac not mid in digital mode");
   chk_dig_zero: assert property (!$past(auto_black_level) |-> red_dig_offset == 9'sd0)
      else $error("digital offset active in analog mode");
   cover property (pos_to_clamp_dac);
   cover property (sync_from_sog);
   cover property (!restore_active);
endmodule // vagr_regs_chk

bind vagr_regs vagr_regs_chk u_chk (
   .ref_clk(ref_clk),
   .reset(reset),
   .hreadyout(hreadyout),
   .hresp(hresp),
   .auto_black_level(auto_black_level),
   .pll_coast(pll_coast),
   .clamp_time(clamp_time),
   .pos_to_clamp_dac(pos_to_clamp_dac),
   .neg_to_pad(neg_to_pad),
   .neg_to_clamp_dac(neg_to_clamp_dac),
   .analog_clamp_on(analog_clamp_on),
   .clamp_level_sel(clamp_level_sel),
   .half_shift_en(half_shift_en),
   .green_target(green_target),
   .sync_from_sog(sync_from_sog),
   .composite_mode(composite_mode),
   .restore_active(restore_active),
   .red_dac(red_dac),
   .red_dig_offset(red_dig_offset)
);

// file: test/video_afe_input_gain_offset_regs_bench.sv
`timescale 1ns/1ps
`include "vagr_map.vh"
module video_afe_input_gain_offset_regs_bench;
   reg ref_clk = 1'b0;
   reg reset = 1'b1;
   reg hsel = 1'b0;
   reg hwrite = 1'b0;
   reg [31:0] haddr = 32'h0;
   reg [31:0] hwdata = 32'h0;
   reg [1:0] htrans = 2'h0;
   reg [2:0] hsize = 3'h0;
   reg auto_black_level = 1'b0, pll_coast = 1'b0, clamp_time = 1'b0;
   wire [31:0] hrdata;
   wire hreadyout, hresp, second_input_set, pos_to_clamp_dac, neg_to_pad, neg_to_clamp_dac;
   wire analog_clamp_on, sync_from_sog, composite_mode, restore_active, dac_quarter_span;
   wire [2:0] clamp_level_sel, half_shift_en;
   wire [7:0] red_target, green_target, blue_target, red_gain, green_gain, blue_gain;
   wire [9:0] red_dac, green_dac, blue_dac;
   wire signed [8:0] red_dig_offset, green_dig_offset, blue_dig_offset;
   integer num_errors = 0;
   integer checks = 0;
   integer i, n;
   reg [31:0] rv;
   reg [7:0] c;
   // one slave: its hreadyout is the bus hready
   vagr_regs dut (
      .ref_clk(ref_clk),
      .reset(reset),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hsize(hsize),
      .hwdata(hwdata),
      .hready(hreadyout),
      .hrdata(hrdata),
      .hreadyout(hreadyout),
      .hresp(hresp),
      .auto_black_level(auto_black_level),
      .pll_coast(pll_coast),
      .clamp_time(clamp_time),
      .second_input_set(second_input_set),
      .pos_to_clamp_dac(pos_to_clamp_dac),
      .neg_to_pad(neg_to_pad),
      .neg_to_clamp_dac(neg_to_clamp_dac),
      .analog_clamp_on(analog_clamp_on),
      .clamp_level_sel(clamp_level_sel),
      .half_shift_en(half_shift_en),
      .red_target(red_target),
      .green_target(green_target),
      .blue_target(blue_target),
      .sync_from_sog(sync_from_sog),
      .composite_mode(composite_mode),
      .restore_active(restore_active),
      .red_gain(red_gain),
      .green_gain(green_gain),
      .blue_gain(blue_gain),
      .red_dac(red_dac),
      .green_dac(green_dac),
      .blue_dac(blue_dac),
      .red_dig_offset(red_dig_offset),
      .green_dig_offset(green_dig_offset),
      .blue_dig_offset(blue_dig_offset),
      .dac_quarter_span(dac_quarter_span)
   );
   initial begin
      forever #4 ref_clk = ~ref_clk;
   end
   // ==========================================================
   // helpers
   function [7:0] v(input integer k);
      v = 8'hc3 + 8'(k * 17);
   endfunction
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checks = checks + 1;
      if (seen !== exp) begin
         num_errors = num_errors + 1;
         $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task xfer(input logic w, input logic [7:0] idx, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      hsize <= 3'b010;
      haddr <= {22'h0, idx, 2'b00};
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hsel <= 1'b0;
      hwdata <= d;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      rv = hrdata;
   endtask
   // two idle edges let the derived outputs land
   task wr(input logic [7:0] idx, input logic [31:0] d);
      xfer(1'b1, idx, d);
      repeat (2) @(posedge ref_clk);
   endtask
   task rdc(input logic [7:0] idx, input logic [31:0] e);
      xfer(1'b0, idx, 32'h0);
      chk(rv, e);
   endtask
   task chk_defaults;
      for (i = 0; i < 8; i = i + 1) rdc(8'h05 + i[7:0], (i == 0 || i == 7) ? 8'h00 :
         (i < 4 ? `VAGR_RST_GAIN : `VAGR_RST_OFFSET));
      chk({red_gain, red_dac, neg_to_clamp_dac, half_shift_en}, {8'h55, 10'h200, 4'hf});
   endtask
   task close_out;
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // ==========================================================
   // tests
   initial begin
      repeat (5) @(posedge ref_clk);
      reset <= 1'b0;
      chk_defaults;
      // upper word bits are junk on purpose; reserved bits read back zero
      for (i = 0; i < 8; i = i + 1) wr(8'h05 + i[7:0], {24'hffffff, v(i)});
      for (i = 0; i < 8; i = i + 1) rdc(8'h05 + i[7:0], v(i) & (i == 0 ? 8'h3f :
         (i == 7 ? 8'hfd : 8'hff)));
      wr(8'h0d, 32'hff);
      rdc(8'h0d, 32'h0);
      chk({red_gain, green_gain, blue_gain}, {v(1), v(2), v(3)});
      chk({red_dac, green_dac, blue_dac, dac_quarter_span},
         {v(4), 2'b10, v(5), 2'b11, v(6), 2'b00, 1'b0});
      wr(`VAGR_IDX_OFFSET_DAC, 32'hc5);
      chk({red_dac[1:0], green_dac[1:0], blue_dac[1:0], dac_quarter_span}, 7'b0100111);
      auto_black_level <= 1'b1;
      for (i = 0; i < 3; i = i + 1) begin
         c = (i == 0) ? 8'h00 : (i == 1 ? 8'h80 : 8'hff);
         wr(`VAGR_IDX_RED_OFFSET, c);
         wr(`VAGR_IDX_GREEN_OFFSET, c);
         wr(`VAGR_IDX_BLUE_OFFSET, c);
         chk({red_dig_offset, green_dig_offset, blue_dig_offset}, {3{{1'b0, c} - 9'h080}});
         chk({red_dac, green_dac, blue_dac}, {3{10'h200}});
      end
      // sweep every setup code against coast and clamp window
      for (n = 0; n < 128; n = n + 1) begin
         pll_coast <= n[6];
         clamp_time <= n[0] ^ n[6];
         wr(`VAGR_IDX_INPUT_SETUP, n[5:0]);
         chk({second_input_set, pos_to_clamp_dac, neg_to_pad, neg_to_clamp_dac, analog_clamp_on,
            restore_active, composite_mode, sync_from_sog}, {n[0], ~n[1] & (n[0] ^ n[6]) &
            ~(n[6] & ~n[5]), n[1], ~n[1], ~n[1] & ~(n[6] & ~n[5]), ~(n[6] & ~n[5]), n[3],
            n[3] & ~n[4]});
         chk({clamp_level_sel, half_shift_en, red_target, green_target, blue_target}, n[2] ?
            {6'b101010, 24'h800080} : {6'b000111, 24'h0});
      end
      // reset in mid-run must bring every default back
      reset <= 1'b1;
      repeat (2) @(posedge ref_clk);
      reset <= 1'b0;
      chk_defaults;
      close_out;
   end
   initial begin
      #100000;
      num_errors = num_errors + 1;
      close_out;
   end
endmodule // video_afe_input_gain_offset_regs_bench
